/* File: src/pwm_output_stage.sv */
// PWM output stage: channel mask, fault brake and polarity, with APB registers
//
// Notes on behaviour
// - Mask enable 0 passes generator, 1 substitutes
// - Masked channel drives its mask data level
// - Mask enable register resets to zero
// - Masked level still passes polarity inversion
// - Fault pin ignored unless pin enable set
// - Edge select: 0 falling, 1 rising
// - Brake overrides channels 0-5 only
// - Braked channel drives its brake data level
// - Brake clears the run bit
// - Brake resets the period counter
// - Brake sets flag and requests interrupt
// - Brake levels persist after flag cleared
// - Setting run bit releases the brake
// - Fault pin debounced for eight clocks
// - ADC compare event brakes like pin
// - Polarity bit 1 inverts the channel
// - Polarity register resets to zero
//
// The APB slave port was left to the implementer.
module pwm_output_stage
#(
  parameter int CHANNELS = 6
) (
  // Clock and reset
  input  wire logic                   CORE_CLK,
  input  wire logic                   RST_N,
  // APB slave
  input  wire pwm_out_pkg::apb_req_type APB_REQ,
  output      pwm_out_pkg::apb_rsp_type APB_RSP,
  // Generator side
  input  wire logic [CHANNELS-1:0]    PWM_GEN,
  input  wire logic                   ADC_CMP_EVENT,
  output      logic                   PWM_RUN,
  output      logic                   COUNTER_CLEAR,
  // Pins and interrupt
  input  wire logic                   FAULT_PIN,
  output      logic [CHANNELS-1:0]    PWM_OUT,
  output      logic                   BRAKE_IRQ
);

  import pwm_out_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]      polarity;
  logic [7:0]      brake_data;
  logic [7:0]      ctrl_zero;
  logic [7:0]      ctrl_one;
  logic [7:0]      mask_enable;
  logic [7:0]      mask_data;
  logic [1:0]      irq_status;
  logic [1:0]      irq_enable;
  brake_state_type state;
  logic            sync1;
  logic            sync2;
  logic [2:0]      warm;
  logic            filt;
  logic            filt_prev;
  logic [3:0]      stable_cnt;
  logic            pin_event;
  logic            brake_event;
  logic            setup;
  logic            wr;
  logic [9:0]      widx;
  logic [31:0]     rd_data;
  logic            rd_hit;
  logic            run_write;
  logic [CHANNELS-1:0] next_level;
  logic [CHANNELS-1:0] next_pins;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Zero wait: data prepared in setup, pready raised in access
  assign setup = APB_REQ.psel && !APB_REQ.penable;
  assign wr    = APB_REQ.psel && APB_REQ.penable && APB_RSP.pready
                 && APB_REQ.pwrite;
  assign widx  = APB_REQ.paddr[11:2];
  assign run_write = wr && widx == {2'b00, IDX_CTRL_ZERO}
                     && APB_REQ.pwdata[RUN_BIT];

  // Read mux, unmapped indices flag an error
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (widx)
      {2'b00, IDX_POLARITY}:    rd_data[7:0] = polarity;
      {2'b00, IDX_BRAKE_DATA}:  rd_data[7:0] = brake_data;
      {2'b00, IDX_CTRL_ZERO}:   rd_data[7:0] = ctrl_zero;
      {2'b00, IDX_CTRL_ONE}:    rd_data[7:0] = ctrl_one;
      {2'b00, IDX_IRQ_STATUS}:  rd_data[1:0] = irq_status;
      {2'b00, IDX_IRQ_CLEAR}:   rd_data[1:0] = 2'h0;
      {2'b00, IDX_IRQ_ENABLE}:  rd_data[1:0] = irq_enable;
      {2'b00, IDX_MASK_ENABLE}: rd_data[7:0] = mask_enable;
      {2'b00, IDX_MASK_DATA}:   rd_data[7:0] = mask_data;
      default:                  rd_hit = 1'b0;
    endcase
  end

  // Response flops
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      APB_RSP <= '0;
    end else begin
      APB_RSP.pready  <= setup;
      APB_RSP.pslverr <= setup && !rd_hit;
      if (setup && !APB_REQ.pwrite) begin
        APB_RSP.prdata <= rd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Plain software registers
  // ----------------------------------------------------------------
  // Upper two bits reserved, read as zero, except in control one, which keeps all eight
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mask_enable <= REG_RESET;
      mask_data   <= REG_RESET;
      polarity    <= REG_RESET;
      ctrl_one    <= REG_RESET;
      irq_enable  <= 2'h0;
    end else if (wr) begin
      case (widx)
        {2'b00, IDX_MASK_ENABLE}: mask_enable <= APB_REQ.pwdata[7:0] & CHAN_FIELD_MASK;
        {2'b00, IDX_MASK_DATA}:   mask_data   <= APB_REQ.pwdata[7:0] & CHAN_FIELD_MASK;
        {2'b00, IDX_POLARITY}:    polarity    <= APB_REQ.pwdata[7:0] & CHAN_FIELD_MASK;
        {2'b00, IDX_CTRL_ONE}:    ctrl_one    <= APB_REQ.pwdata[7:0];
        {2'b00, IDX_IRQ_ENABLE}:  irq_enable  <= APB_REQ.pwdata[1:0] & IRQ_FIELD_MASK;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Fault pin synchroniser and debounce
  // ----------------------------------------------------------------
  // Two flops before anything looks at the pin
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      warm  <= 3'h0;
    end else begin
      sync1 <= FAULT_PIN;
      sync2 <= sync1;
      warm  <= {warm[1:0], 1'b1};                        // Sets once the pair holds the pin
    end
  end

  // Level accepted only after eight equal samples; shorter glitches vanish
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stable_cnt <= 4'h0;
      filt       <= 1'b0;
      filt_prev  <= 1'b0;
    end else begin
      filt_prev <= filt;
      if (!warm[2]) begin
        filt      <= sync2;                              // Preload so reset gives no false edge
        filt_prev <= sync2;
      end else if (sync2 == filt) begin
        stable_cnt <= 4'h0;
      end else if (stable_cnt == 4'(DEBOUNCE_CYCLES - 1)) begin
        stable_cnt <= 4'h0;
        filt       <= sync2;
      end else begin
        stable_cnt <= stable_cnt + 4'h1;
      end
    end
  end

  // Edge qualification and source merge
  assign pin_event = ctrl_one[PIN_ENABLE_BIT]
                     && (brake_data[EDGE_SEL_BIT] ? (filt && !filt_prev)
                                                  : (!filt && filt_prev));
  assign brake_event = pin_event || ADC_CMP_EVENT;

  // ----------------------------------------------------------------
  // Brake state machine
  // ----------------------------------------------------------------
  // A new fault in the release cycle wins, keeping the pins safe
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_NORMAL;
    end else begin
      case (state)
        ST_NORMAL: if (brake_event) state <= ST_BRAKE;
        ST_BRAKE:  if (run_write && !brake_event) state <= ST_NORMAL;
        default:   state <= ST_NORMAL;
      endcase
    end
  end

  // Control zero: run bit cleared by hardware on a brake
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_zero <= REG_RESET;
    end else begin
      if (wr && widx == {2'b00, IDX_CTRL_ZERO}) begin
        ctrl_zero <= APB_REQ.pwdata[7:0];
      end
      if (brake_event) begin
        ctrl_zero[RUN_BIT] <= 1'b0;
      end
    end
  end

  // Brake data with flag; writing 0 clears the flag, set wins
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      brake_data <= REG_RESET;
    end else begin
      if (wr && widx == {2'b00, IDX_BRAKE_DATA}) begin
        brake_data[6:0] <= APB_REQ.pwdata[6:0];
        if (!APB_REQ.pwdata[FLAG_BIT]) begin
          brake_data[FLAG_BIT] <= 1'b0;
        end
      end
      if (brake_event) begin
        brake_data[FLAG_BIT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, clear and request
  // ----------------------------------------------------------------
  // Write one to clear; a same-cycle event keeps its bit
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_status <= 2'h0;
    end else begin
      if (wr && widx == {2'b00, IDX_IRQ_CLEAR}) begin
        irq_status <= irq_status & ~APB_REQ.pwdata[1:0];
      end
      if (brake_event) begin
        irq_status[IRQ_BRAKE_BIT] <= 1'b1;
      end
      if (state == ST_BRAKE && run_write && !brake_event) begin
        irq_status[IRQ_RELEASE_BIT] <= 1'b1;
      end
    end
  end

  // Output flops; irq lags status by one clock
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      BRAKE_IRQ     <= 1'b0;
      PWM_RUN       <= 1'b0;
      COUNTER_CLEAR <= 1'b0;
    end else begin
      BRAKE_IRQ     <= |(irq_status & irq_enable);
      PWM_RUN       <= ctrl_zero[RUN_BIT];
      COUNTER_CLEAR <= brake_event;
    end
  end

  // ----------------------------------------------------------------
  // Channel path: generator, mask, brake, polarity
  // ----------------------------------------------------------------
  // Brake beats mask; polarity last so safe levels are inverted by polarity too
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      next_level[i] = mask_enable[i] ? mask_data[i] : PWM_GEN[i];
      if (state == ST_BRAKE) begin
        next_level[i] = brake_data[i];
      end
      next_pins[i] = next_level[i] ^ polarity[i];
    end
  end

  // Pin flops
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PWM_OUT <= '0;
    end else begin
      PWM_OUT <= next_pins;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_brake_event;
    brake_event;
  endsequence
  sequence s_brake_response;
    !ctrl_zero[RUN_BIT] ##0 brake_data[FLAG_BIT] ##0 state == ST_BRAKE;
  endsequence

  property p_mask_pass;
    @(posedge CORE_CLK) disable iff (!RST_N)
    state == ST_NORMAL && mask_enable == 8'h00 && polarity == 8'h00
      |=> PWM_OUT == $past(PWM_GEN);
  endproperty
  a_mask_pass: assert property (p_mask_pass)
    else $error("unmasked channel did not follow generator");

  property p_mask_level;
    @(posedge CORE_CLK) disable iff (!RST_N)
    state == ST_NORMAL && mask_enable == CHAN_FIELD_MASK
      |=> PWM_OUT == $past(mask_data[CHANNELS-1:0] ^ polarity[CHANNELS-1:0]);
  endproperty
  a_mask_level: assert property (p_mask_level)
    else $error("masked channel not at mask level");

  property p_reset_values;
    @(posedge CORE_CLK) $rose(RST_N) |-> mask_enable == 8'h00 && polarity == 8'h00;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("mask or polarity not zero after reset");

  property p_pin_gate;
    @(posedge CORE_CLK) disable iff (!RST_N)
    !ctrl_one[PIN_ENABLE_BIT] && !ADC_CMP_EVENT |=> state == $past(state)
      || $past(run_write);
  endproperty
  a_pin_gate: assert property (p_pin_gate)
    else $error("brake entered with pin input disabled");

  property p_brake_effect;
    @(posedge CORE_CLK) disable iff (!RST_N)
    s_brake_event |=> s_brake_response ##0 COUNTER_CLEAR;
  endproperty
  a_brake_effect: assert property (p_brake_effect)
    else $error("brake did not stop run, set flag or clear counter");

  property p_brake_levels;
    @(posedge CORE_CLK) disable iff (!RST_N)
    state == ST_BRAKE
      |=> PWM_OUT == $past(brake_data[CHANNELS-1:0] ^ polarity[CHANNELS-1:0]);
  endproperty
  a_brake_levels: assert property (p_brake_levels)
    else $error("braked channel not at brake level");

  property p_brake_hold;
    @(posedge CORE_CLK) disable iff (!RST_N)
    state == ST_BRAKE && !run_write |=> state == ST_BRAKE;
  endproperty
  a_brake_hold: assert property (p_brake_hold)
    else $error("brake released without run bit");

  property p_release;
    @(posedge CORE_CLK) disable iff (!RST_N)
    state == ST_BRAKE && run_write && !brake_event
      |=> state == ST_NORMAL ##1 PWM_RUN;
  endproperty
  a_release: assert property (p_release)
    else $error("run bit set but brake kept");

  property p_debounce;
    @(posedge CORE_CLK) disable iff (!RST_N)
    $past(warm[2]) && filt != $past(filt) |-> $past(stable_cnt) == 4'(DEBOUNCE_CYCLES - 1);
  endproperty
  a_debounce: assert property (p_debounce)
    else $error("fault level accepted before debounce");

  property p_irq;
    @(posedge CORE_CLK) disable iff (!RST_N)
    s_brake_event ##0 irq_enable[IRQ_BRAKE_BIT] |=> ##1 BRAKE_IRQ;
  endproperty
  a_irq: assert property (p_irq)
    else $error("brake interrupt not raised");

endmodule : pwm_output_stage

/* File: src/pwm_out_pkg.sv */
// Constants and carrier types for the PWM output mask, brake and polarity stage
package pwm_out_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_POLARITY    = 8'hd6;
  localparam logic [7:0] IDX_BRAKE_DATA  = 8'hd7;
  localparam logic [7:0] IDX_CTRL_ZERO   = 8'hd8;
  localparam logic [7:0] IDX_CTRL_ONE    = 8'hdf;
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'he4;
  localparam logic [7:0] IDX_IRQ_CLEAR   = 8'he5;
  localparam logic [7:0] IDX_IRQ_ENABLE  = 8'he6;
  localparam logic [7:0] IDX_MASK_ENABLE = 8'hfb;
  localparam logic [7:0] IDX_MASK_DATA   = 8'hfc;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         RUN_BIT         = 7;
  localparam int         PIN_ENABLE_BIT  = 3;
  localparam int         FLAG_BIT        = 7;
  localparam int         EDGE_SEL_BIT    = 6;
  localparam int         IRQ_BRAKE_BIT   = 0;
  localparam int         IRQ_RELEASE_BIT = 1;
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [7:0] CHAN_FIELD_MASK = 8'h3f;
  localparam logic [1:0] IRQ_FIELD_MASK  = 2'h3;

  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam int         DEBOUNCE_CYCLES = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_NORMAL = 2'b01,
    ST_BRAKE  = 2'b10
  } brake_state_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_type;

endpackage : pwm_out_pkg

/* File: tb/fault_sensor_model.sv */
// Behavioural model of the external fault sensor that drives the fault pin
module fault_sensor_model (
  // Clock
  input  wire logic       CORE_CLK,
  // Control from the bench
  input  wire logic       GO,
  input  wire logic       IDLE_LEVEL,
  input  wire logic [4:0] PULSE_LEN,
  // Pin
  output      logic       FAULT_PIN
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [4:0] remain = 5'h00;

  // Pulse length counter; a short pulse is only sent when the bench asks for one
  always @(posedge CORE_CLK) begin
    if (GO) begin
      remain <= PULSE_LEN;
    end else if (remain != 5'h00) begin
      remain <= remain - 5'h01;
    end
  end

  // Pin sits at its idle level between pulses
  assign FAULT_PIN = (remain != 5'h00) ? ~IDLE_LEVEL : IDLE_LEVEL;
endmodule : fault_sensor_model

/* File: tb/tb_top.sv */
// Self-checking testbench for the PWM output stage
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pwm_out_pkg::*;

  logic        core_clk = 1'b0;
  logic        rst_n;
  apb_req_type req;
  apb_rsp_type rsp;
  logic [5:0]  gen, pout, men, md, bd, pol;
  logic        adc_evt, run, cclr, pin, irq, go, idle;
  logic [4:0]  plen;
  logic [31:0] rd;
  logic        er;
  int          err_total, num_checks, cyc, clr_seen, seed, i;
  logic [7:0]  regs [5] = '{IDX_POLARITY, IDX_BRAKE_DATA, IDX_CTRL_ONE, IDX_MASK_ENABLE,
                            IDX_MASK_DATA};

  // ----------------------------------------------------------------
  // Design and far side
  // ----------------------------------------------------------------
  pwm_output_stage #(.CHANNELS(6)) pwm_output_stage_inst (
    .CORE_CLK(core_clk), .RST_N(rst_n), .APB_REQ(req), .APB_RSP(rsp), .PWM_GEN(gen),
    .ADC_CMP_EVENT(adc_evt), .PWM_RUN(run), .COUNTER_CLEAR(cclr), .FAULT_PIN(pin),
    .PWM_OUT(pout), .BRAKE_IRQ(irq));

  fault_sensor_model fault_sensor_model_inst (
    .CORE_CLK(core_clk), .GO(go), .IDLE_LEVEL(idle), .PULSE_LEN(plen), .FAULT_PIN(pin));

  // ----------------------------------------------------------------
  // Clock, timeout and counter-clear pulse tally
  // ----------------------------------------------------------------
  always #2 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cclr === 1'b1) clr_seen <= clr_seen + 1;
    if (cyc > 20000) begin
      err_total++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] rnd6();
    int v;
    v = $random(seed);
    return v[5:0];
  endfunction : rnd6

  // Brake beats mask, polarity last
  function automatic logic [5:0] expected_pins(input logic brk);
    return (brk ? bd : ((men & md) | (~men & gen))) ^ pol;
  endfunction : expected_pins

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One APB transfer; waits for pready rather than assuming a latency
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge core_clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= {2'b00, idx, 2'b00};
    req.pwdata  <= wd;
    @(posedge core_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(name, exp, rd);
  endtask : rdchk

  task automatic pins_chk(input logic brk);
    repeat (4) @(posedge core_clk);
    chk("pwm_out", {26'h0, expected_pins(brk)}, {26'h0, pout});
  endtask : pins_chk

  task automatic adc_pulse();
    @(posedge core_clk) adc_evt <= 1'b1;
    @(posedge core_clk) adc_evt <= 1'b0;
  endtask : adc_pulse

  // Pin edge case: level and edge select changed only while the pin input is disabled
  task automatic pin_case(input logic en, input logic sel, input logic lvl,
                          input logic [4:0] len, input logic brk);
    apb(1'b1, IDX_CTRL_ONE, 32'h0);
    idle <= lvl;
    apb(1'b1, IDX_BRAKE_DATA, {24'h0, 1'b0, sel, bd});
    repeat (20) @(posedge core_clk);
    apb(1'b1, IDX_CTRL_ONE, {28'h0, en, 3'h0});
    clr_seen = 0;
    plen <= len;
    @(posedge core_clk) go <= 1'b1;
    @(posedge core_clk) go <= 1'b0;
    repeat (20) @(posedge core_clk);
    pins_chk(brk);
    chk("clear_pulses", {31'h0, brk}, clr_seen);
    apb(1'b1, IDX_CTRL_ZERO, 32'h80);
  endtask : pin_case

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 27592;
    rst_n = 1'b0;
    req = '0;
    {gen, men, md, bd, pol} = '0;
    {adc_evt, go, plen} = '0;
    idle = 1'b1;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    // Reset values and an unmapped place
    for (i = 0; i < 5; i++) rdchk("reset_value", regs[i], 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    apb(1'b1, IDX_IRQ_ENABLE, 32'h1);
    apb(1'b1, IDX_CTRL_ZERO, 32'h80);
    // Random mask, level and polarity, with all-masked and none-masked corners
    for (i = 0; i < 12; i++) begin
      gen <= rnd6();
      men = (i == 0) ? 6'h3f : (i == 1) ? 6'h00 : rnd6();
      md = rnd6();
      pol = rnd6();
      apb(1'b1, IDX_MASK_ENABLE, {26'h0, men});
      apb(1'b1, IDX_MASK_DATA, {26'h0, md});
      apb(1'b1, IDX_POLARITY, {26'h0, pol});
      pins_chk(1'b0);
    end
    // Brake by ADC compare event
    bd = rnd6();
    apb(1'b1, IDX_BRAKE_DATA, {26'h0, bd});
    clr_seen = 0;
    adc_pulse();
    pins_chk(1'b1);
    chk("pwm_run", 32'h0, {31'h0, run});
    chk("clear_pulses", 32'h1, clr_seen);
    chk("irq", 32'h1, {31'h0, irq});
    rdchk("brake_data", IDX_BRAKE_DATA, {24'h0, 2'b10, bd});
    apb(1'b1, IDX_BRAKE_DATA, {26'h0, bd});
    gen <= rnd6();
    pins_chk(1'b1);
    rdchk("flag_cleared", IDX_BRAKE_DATA, {26'h0, bd});
    apb(1'b1, IDX_CTRL_ZERO, 32'h80);
    pins_chk(1'b0);
    chk("pwm_run", 32'h1, {31'h0, run});
    rdchk("irq_release", IDX_IRQ_STATUS, 32'h3);
    apb(1'b1, IDX_IRQ_CLEAR, 32'h3);
    repeat (3) @(posedge core_clk);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    // Masked interrupt: status still set
    apb(1'b1, IDX_IRQ_ENABLE, 32'h0);
    adc_pulse();
    repeat (3) @(posedge core_clk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rdchk("irq_status", IDX_IRQ_STATUS, 32'h1);
    apb(1'b1, IDX_CTRL_ZERO, 32'h80);
    apb(1'b1, IDX_IRQ_CLEAR, 32'h3);
    // Fault pin: disabled, short pulse, falling and rising edges
    pin_case(1'b0, 1'b0, 1'b1, 5'd12, 1'b0);
    pin_case(1'b1, 1'b0, 1'b1, 5'd4, 1'b0);
    pin_case(1'b1, 1'b0, 1'b1, 5'd12, 1'b1);
    pin_case(1'b1, 1'b1, 1'b0, 5'd12, 1'b1);
    end_of_test();
  end
endmodule : tb_top
